//--- hw/sram_host_pkg.sv
// Package for the static RAM host controller: widths, timing figures and cycle counts.
// Assumes a 40 MHz controller clock; all figures are for the slower speed grade.
package sram_host_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam int MEM_WORDS = 2048;
	localparam int CLK_PERIOD_NS = 25;
	// Slower grade figures, in ns, so a controller built on them suits both grades
	localparam int READ_CYCLE_MIN_NS = 120;
	localparam int ADDRESS_TO_DATA_TIME_NS = 120;
	localparam int SELECT_TO_DATA_TIME_NS = 120;
	localparam int OUTPUT_DRIVE_ACCESS_TIME_NS = 50;
	localparam int DESELECT_TO_FLOAT_TIME_NS = 40;
	localparam int OUTPUT_DISABLE_FLOAT_TIME_NS = 40;
	localparam int WRITE_PULSE_MIN_NS = 70;
	localparam int SELECT_TO_WRITE_END_NS = 70;
	localparam int ADDRESS_VALID_TO_WRITE_END_NS = 105;
	localparam int WRITE_CYCLE_MIN_NS = 120;
	localparam int WRITE_FLOAT_TIME_NS = 35;
	localparam int CNT_W = 4;
	// Least times round up to whole cycles
	localparam logic [CNT_W-1:0] READ_CYCLES =
		CNT_W'((READ_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] AWAIT_CYCLES =
		CNT_W'((ADDRESS_VALID_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WCYCLE_CYCLES =
		CNT_W'((WRITE_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] FLOAT_CYCLES =
		CNT_W'((OUTPUT_DISABLE_FLOAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sram_req_t;

	typedef struct packed {
		logic              select_n;
		logic              write_n;
		logic              drive_n;
		logic [ADDR_W-1:0] addr;
	} sram_ctl_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_READ  = 3'b001,
		ST_RDONE = 3'b010,
		ST_WRITE = 3'b011,
		ST_WREC  = 3'b100,
		ST_FLOAT = 3'b101
	} state_t;
endpackage : sram_host_pkg

//--- hw/sram_host.sv
// Clocked host controller for a 2K x 8 asynchronous static RAM.
// Assumes the memory sits on the pins below and requests arrive one at a time.
// How it works
// RQ1: Memory holds 2048 words of 8 bits.
// RQ2: Select high puts memory in standby.
// RQ3: Deselected memory floats its data pins.
// RQ4: Write happens while select and strobe low.
// RQ5: Select low, strobe high reads data.
// RQ6: Drive enable high keeps pins floating.
// RQ7: Address changes only with strobe, select high.
// RQ8: Strobe write keeps select low throughout.
// RQ9: Select write keeps strobe low throughout.
// RQ10: Address to data within access time.
// RQ11: Read cycle lasts at least cycle minimum.
// RQ12: Select to data within access time.
// RQ13: Deselect floats pins within 40 ns.
// RQ14: Drive enable to data within limit.
// RQ15: Host waits for float after drive off.
// RQ16: Old data held 10 ns after address.
// RQ17: Write strobe low long enough.
// RQ18: Select low long enough before write end.
// RQ19: Address valid long enough before write end.
// RQ20: Write cycle lasts at least cycle minimum.
// RQ21: Strobe fall floats outputs quickly.
// RQ22: No drive soon after write end.
// RQ23: Select falling with strobe keeps pins floated.
// RQ24: Round minimums up; drive bus when floated.
`timescale 1ns/100ps
module sram_host
	import sram_host_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Request side
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire sram_req_t         req,
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_data,
	// Memory pins
	output logic                   select_n,
	output logic                   write_n,
	output logic                   drive_n,
	output logic [ADDR_W-1:0]      mem_addr,
	input  wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0]      data_out,
	output logic                   data_oe_n
);
	state_t            state_reg, state_next;
	logic [CNT_W-1:0]  cnt_reg, cnt_next;
	sram_ctl_t         ctl_reg, ctl_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic              oe_n_reg, oe_n_next;
	logic              rsp_valid_reg, rsp_valid_next;
	logic [DATA_W-1:0] rsp_data_reg, rsp_data_next;

	wire logic        idle_w = (state_reg == ST_IDLE);
	wire logic        cnt_done_w = (cnt_reg == CNT_ONE);
	// Request decode; only an idle controller takes a request
	wire logic        take_w = idle_w && req_valid;
	wire logic        take_write_w = take_w && req.write;
	wire logic        read_end_w = (state_reg == ST_READ) && cnt_done_w;
	wire logic        write_end_w = (state_reg == ST_WRITE) && cnt_done_w;
	// Released controls keep the last address, so no address edge meets a low strobe
	wire sram_ctl_t   ctl_idle_w = '{
		select_n: 1'b1,
		write_n:  1'b1,
		drive_n:  1'b1,
		addr:     ctl_reg.addr
	};

	assign req_ready = idle_w;
	assign select_n  = ctl_reg.select_n;
	assign write_n   = ctl_reg.write_n;
	assign drive_n   = ctl_reg.drive_n;
	assign mem_addr  = ctl_reg.addr;
	assign data_out  = wdata_reg;
	assign data_oe_n = oe_n_reg;
	assign rsp_valid = rsp_valid_reg;
	assign rsp_data  = rsp_data_reg;

	function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] c);
		dec = (c == CNT_ZERO) ? CNT_ZERO : c - CNT_ONE;
	endfunction : dec

	// Counters load a cycle count, run down to one and then rest at zero
	always_comb begin
		state_next     = state_reg;
		cnt_next       = dec(cnt_reg);
		ctl_next       = ctl_reg;
		wdata_next     = wdata_reg;
		oe_n_next      = oe_n_reg;
		rsp_valid_next = 1'b0;
		rsp_data_next  = rsp_data_reg;
		case (state_reg)
			ST_IDLE: begin
				ctl_next  = ctl_idle_w; // RQ2
				oe_n_next = 1'b1;
				if (take_w) begin
					// Address changes while select and strobe are high
					ctl_next.addr = req.addr; // RQ7
					if (take_write_w) begin
						// Select and strobe fall together so the memory never drives
						ctl_next.select_n = 1'b0; // RQ9 RQ23
						ctl_next.write_n  = 1'b0; // RQ4 RQ8
						wdata_next        = req.wdata;
						oe_n_next         = 1'b0; // RQ24 RQ21
						cnt_next          = AWAIT_CYCLES; // RQ17 RQ18 RQ19
						state_next        = ST_WRITE;
					end else begin
						ctl_next.select_n = 1'b0; // RQ5
						ctl_next.drive_n  = 1'b0; // RQ14
						cnt_next          = READ_CYCLES; // RQ10 RQ11 RQ12
						state_next        = ST_READ;
					end
				end
			end

			ST_READ: begin
				if (read_end_w) begin
					// Sampled at the last edge of the read cycle, after the access time
					rsp_data_next  = data_in; // RQ10 RQ12 RQ14
					rsp_valid_next = 1'b1;
					ctl_next       = ctl_idle_w; // RQ13 RQ15
					cnt_next       = FLOAT_CYCLES;
					state_next     = ST_FLOAT;
				end
			end

			ST_WRITE: begin
				if (write_end_w) begin
					// Both controls rise together; data is held one more cycle
					ctl_next   = ctl_idle_w; // RQ8 RQ9
					cnt_next   = WCYCLE_CYCLES - AWAIT_CYCLES + CNT_ONE; // RQ20
					state_next = ST_WREC;
				end
			end

			ST_WREC: begin
				oe_n_next = 1'b1; // RQ22
				if (cnt_done_w)
					state_next = ST_IDLE;
			end

			ST_FLOAT: begin
				// Wait out the float time before anyone may drive the bus again
				if (cnt_done_w)
					state_next = ST_IDLE; // RQ15 RQ24
			end

			// Unused state codes fall back to a released bus
			default: begin
				ctl_next   = ctl_idle_w;
				oe_n_next  = 1'b1;
				state_next = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Cycle counter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cnt_reg <= CNT_ZERO;
		else
			cnt_reg <= cnt_next;
	end

	// Memory controls; reset releases every strobe at once
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			ctl_reg <= '{
				select_n: 1'b1,
				write_n:  1'b1,
				drive_n:  1'b1,
				addr:     '0
			};
		else
			ctl_reg <= ctl_next;
	end

	// Write data, held one cycle past the strobe rise for hold time
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			wdata_reg <= '0;
		else
			wdata_reg <= wdata_next;
	end

	// Bus drive enable; low only while the memory is sure to float
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			oe_n_reg <= 1'b1;
		else
			oe_n_reg <= oe_n_next;
	end

	// Answer pulse
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rsp_valid_reg <= 1'b0;
		else
			rsp_valid_reg <= rsp_valid_next;
	end

	// Read data holds until the next read ends
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rsp_data_reg <= '0;
		else
			rsp_data_reg <= rsp_data_next;
	end
endmodule : sram_host

//--- bench/sram_host_properties.sv
// Checker for the host pin timing and the request handshake.
// Assumes a 25 ns clock, with every least time rounded up to a whole count of cycles.
`timescale 1ns/100ps
module sram_host_checker
	import sram_host_pkg::*;
(
	input wire logic              clk,
	input wire logic              reset_n,
	input wire logic              req_valid,
	input wire logic              req_ready,
	input wire sram_req_t         req,
	input wire logic              rsp_valid,
	input wire logic              select_n,
	input wire logic              write_n,
	input wire logic              drive_n,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic              data_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_addr_hold: assert property (!$past(select_n) && !select_n |-> $stable(mem_addr))
		else $error("address moved while selected");
	chk_strobe_in_sel: assert property (!write_n |-> !select_n) else $error("strobe alone");
	chk_write_width: assert property ($fell(write_n) |-> !write_n[*5])
		else $error("write strobe short");
	chk_read_width: assert property ($fell(select_n) && write_n |-> !select_n[*5])
		else $error("read cycle short");
	chk_bus_free: assert property (!drive_n |-> data_oe_n) else $error("bus clash");
	chk_float_wait: assert property ($rose(drive_n) |-> data_oe_n[*2])
		else $error("drove bus before float");
	chk_read_answer: assert property (req_valid && req_ready && !req.write |-> ##6 rsp_valid)
		else $error("read answer late");
	chk_write_busy: assert property (req_valid && req_ready && req.write |=> !req_ready[*5])
		else $error("write cycle short");
	cover property ($fell(write_n));
	cover property (rsp_valid);
	cover property ($rose(drive_n));
endmodule : sram_host_checker
bind sram_host sram_host_checker i_chk (.*);

//--- bench/sram_model.sv
// Behavioural 2K x 8 static RAM on the host pins.
// Assumes no pull on the bus: a released bus shows inverted old data.
`timescale 1ns/100ps
module sram_model
	import sram_host_pkg::*;
(
	input wire logic              select_n,
	input wire logic              write_n,
	input wire logic              drive_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] din,
	output logic [DATA_W-1:0]     q
);
	logic [DATA_W-1:0] mem [MEM_WORDS];
	logic [DATA_W-1:0] last = 8'h00;
	logic [ADDR_W-1:0] acap;
	logic              wr_act = 1'b0;
	wire               rd = !select_n && write_n && !drive_n;
	always @(negedge select_n or negedge write_n) if (!select_n && !write_n) begin
		acap = addr;
		wr_act = 1'b1;
	end
	always @(posedge select_n or posedge write_n) if (wr_act) begin
		mem[acap] = din;
		wr_act = 1'b0;
	end
	always @* if (rd) last = mem[addr];
	assign q = rd ? mem[addr] : ~last;
endmodule : sram_model

//--- bench/tb.sv
// Bench: host controller driving the behavioural static RAM.
// Assumes 40 MHz; inputs change at the falling edge.
`timescale 1ns/100ps
module tb;
	import sram_host_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic req_valid = 1'b0;
	sram_req_t req = '0;
	logic req_ready, rsp_valid, select_n, write_n, drive_n, data_oe_n;
	logic [DATA_W-1:0] rsp_data, data_out, mem_q;
	logic [ADDR_W-1:0] mem_addr;
	wire [DATA_W-1:0] data_in = data_oe_n ? mem_q : data_out;
	int n_errors = 0;
	int n_checks = 0;
	int n_rsp = 0;
	// Write flag, address, write data, expected read data
	logic [27:0] rows [6] = '{{1'b1,11'h000,16'ha500}, {1'b1,11'h7ff,16'h3c00},
		{1'b0,11'h000,16'h00a5}, {1'b0,11'h7ff,16'h003c},
		{1'b1,11'h7ff,16'hc300}, {1'b0,11'h7ff,16'h00c3}};
	sram_host i_sram_host(.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.select_n(select_n), .write_n(write_n), .drive_n(drive_n), .mem_addr(mem_addr),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
	sram_model i_sram_model(.select_n(select_n), .write_n(write_n), .drive_n(drive_n),
		.addr(mem_addr), .din(data_in), .q(mem_q));
	initial forever #12.5 clk = ~clk;
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task xfer(input logic [27:0] r);
		@(negedge clk);
		req = r[27:8];
		req_valid = 1'b1;
		for (int i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		for (int i = 0; i < 20 && req_ready !== 1'b1; i++) begin
			@(negedge clk);
			if (rsp_valid === 1'b1) n_rsp++;
		end
		chk("ready back", {7'h0, req_ready}, 8'h01);
	endtask : xfer
	task final_report;
		if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : final_report
	initial begin
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		chk("idle pins", {4'h0, select_n, write_n, drive_n, data_oe_n}, 8'h0f);
		foreach (rows[i]) begin
			n_rsp = 0;
			xfer(rows[i]);
			chk("answer pulse", n_rsp[7:0], {7'h0, !rows[i][27]});
			if (rows[i][27]) chk("stored", i_sram_model.mem[rows[i][26:16]], rows[i][15:8]);
			else chk("read data", rsp_data, rows[i][7:0]);
		end
		// Reset in mid-read must drop every strobe at once
		xfer({1'b0, 11'h000, 16'h00a5});
		req = {1'b0, 11'h7ff, 8'h00};
		req_valid = 1'b1;
		repeat (3) @(negedge clk);
		reset_n = 1'b0;
		req_valid = 1'b0;
		#1 chk("reset pins", {3'h0, req_ready, select_n, write_n, drive_n, data_oe_n}, 8'h1f);
		@(negedge clk) reset_n = 1'b1;
		xfer({1'b0, 11'h7ff, 16'h00c3});
		chk("after reset", rsp_data, 8'hc3);
		final_report();
	end
	initial begin
		#(3000 * 25);
		n_errors++;
		final_report();
	end
endmodule : tb
